// ### hw/power_mode_overrange_status.sv
/*
  low-power control, link fill in standby, diode export selection, fast
  threshold alert and per virtual converter sticky overrange status.
  assumes samples, overrange and converter index arrive together on clk;
  the low-power pin is asynchronous; the registers sit behind the serial port.
*/
`timescale 1ns/100ps
`include "pmor_cfg.svh"
// What this block does
// - pin alone requests full power-down, or standby when PWRB_PIN_STBY is set
// - low-power pin is active high
// - power-down drops the serial link
// - registers also request power-down
// - standby keeps link, sends zero samples
// - fill bit selects /K/ in standby
// - diode select one exports 1x diode
// - diode select two exports 20x diode
// - overrange travels aligned with its sample
// - overrange as control bit when enabled
// - sticky overrange bit per virtual converter
// - one then zero write clears bit
// - threshold compare drives alert pin
module power_mode_overrange_status
  import pmor_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int WORD_W = 16,
  parameter int VC_NUM = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial control port pins
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // low-power request pin
  input wire logic lowPowerRequestPin,
  // converter samples
  input wire logic signed [SAMPLE_W-1:0] convSample,
  input wire logic sampleValid,
  input wire logic overrangeIn,
  input wire logic [2:0] vcIndex,
  // link configuration and alert threshold
  input wire logic [1:0] controlBitsPerSample,
  input wire logic [SAMPLE_W-1:0] alertThreshold,
  // link output
  output logic linkEnable,
  output logic linkValid,
  output logic [WORD_W-1:0] linkWord,
  output logic linkIsControl,
  // status and analog controls
  output logic thresholdAlertPin,
  output logic fullPowerDown,
  output logic standbyActive,
  output logic diode1xExport,
  output logic diode20xExport,
  output logic referenceExport,
  output logic commonModeExport
);
  localparam int CB_W = WORD_W - SAMPLE_W;

  // parameter checks
  if (CB_W < 1 || VC_NUM < 1 || VC_NUM > 8 || WORD_W != 16) begin : g_check
    $error("unsupported width or converter count");
  end

  reg_access_if bus ();
  logic pinS1_r, pinS2_r;
  logic [7:0] devSel_r, devSel_nxt, pwrA_r, pwrA_nxt, pwrB_r, pwrB_nxt;
  logic [7:0] ovrClr_r, ovrClr_nxt, fill_r, fill_nxt;
  logic [7:0] refExp_r, refExp_nxt, cmExp_r, cmExp_nxt, diode_r, diode_nxt;
  logic [7:0] sticky_r, sticky_nxt, setVec, clrFall;
  power_state_t pwrState_r, pwrState_nxt;
  logic [WORD_W-1:0] word_r, word_nxt;
  logic valid_r, valid_nxt, ctrl_r, ctrl_nxt, alert_r, alert_nxt;
  logic [CB_W-1:0] ctrlField;
  logic [SAMPLE_W-1:0] magnitude;
  logic wrClr;

  // serial access to the registers
  serial_reg_port u_port (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .serialClk(serialClk),
    .selectN(selectN),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .serialOutEn(serialOutEn),
    .bus(bus)
  );

  // low-power pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1_r <= 1'b0;
      pinS2_r <= 1'b0;
    end else if (ce) begin
      pinS1_r <= lowPowerRequestPin;
      pinS2_r <= pinS1_r;
    end
  end

  // clear register falling bits and sticky set requests
  assign wrClr = bus.wrStb && bus.addr == `OFS_OVR_CLEAR;
  assign clrFall = wrClr ? (ovrClr_r & ~bus.wrData) : 8'h00;
  always_comb begin
    setVec = 8'h00;
    if (sampleValid && overrangeIn && int'(vcIndex) < VC_NUM) begin
      setVec[vcIndex] = 1'b1;
    end
  end

  // register writes and sticky status
  always_comb begin
    devSel_nxt = devSel_r;
    pwrA_nxt = pwrA_r;
    pwrB_nxt = pwrB_r;
    ovrClr_nxt = ovrClr_r;
    fill_nxt = fill_r;
    refExp_nxt = refExp_r;
    cmExp_nxt = cmExp_r;
    diode_nxt = diode_r;
    if (bus.wrStb) begin
      case (bus.addr)
        `OFS_DEVICE_SELECT: devSel_nxt = bus.wrData;
        `OFS_POWER_A: pwrA_nxt = bus.wrData;
        `OFS_POWER_B: pwrB_nxt = bus.wrData;
        `OFS_OVR_CLEAR: ovrClr_nxt = bus.wrData;
        `OFS_STANDBY_FILL: fill_nxt = bus.wrData;
        `OFS_REF_EXPORT: refExp_nxt = bus.wrData;
        `OFS_CM_EXPORT: cmExp_nxt = bus.wrData;
        `OFS_DIODE_SEL: diode_nxt = bus.wrData;
        default: devSel_nxt = devSel_r; // unmapped writes dropped
      endcase
    end
    // set applied after clear so a coincident event survives
    sticky_nxt = (sticky_r & ~clrFall) | setVec;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      devSel_r <= `REG_RESET;
      pwrA_r <= `REG_RESET;
      pwrB_r <= `REG_RESET;
      ovrClr_r <= `REG_RESET;
      fill_r <= `REG_RESET;
      refExp_r <= `REG_RESET;
      cmExp_r <= `REG_RESET;
      diode_r <= `REG_RESET;
      sticky_r <= `REG_RESET;
    end else if (ce) begin
      devSel_r <= devSel_nxt;
      pwrA_r <= pwrA_nxt;
      pwrB_r <= pwrB_nxt;
      ovrClr_r <= ovrClr_nxt;
      fill_r <= fill_nxt;
      refExp_r <= refExp_nxt;
      cmExp_r <= cmExp_nxt;
      diode_r <= diode_nxt;
      sticky_r <= sticky_nxt;
    end
  end

  // read data
  always_comb begin
    case (bus.addr)
      `OFS_DEVICE_SELECT: bus.rdData = devSel_r;
      `OFS_POWER_A: bus.rdData = pwrA_r;
      `OFS_POWER_B: bus.rdData = pwrB_r;
      `OFS_OVR_CLEAR: bus.rdData = ovrClr_r;
      `OFS_OVR_STATUS: bus.rdData = sticky_r;
      `OFS_STANDBY_FILL: bus.rdData = fill_r;
      `OFS_REF_EXPORT: bus.rdData = refExp_r;
      `OFS_CM_EXPORT: bus.rdData = cmExp_r;
      `OFS_DIODE_SEL: bus.rdData = diode_r;
      default: bus.rdData = `READ_ZERO;
    endcase
  end

  // low-power state: deepest request wins
  always_comb begin
    if (pwrA_r[`PWRA_MODE] > `MODE_STANDBY || (pinS2_r && !pwrB_r[`PWRB_PIN_STBY])) begin
      pwrState_nxt = PWR_DOWN;
    end else if (pwrA_r[`PWRA_MODE] == `MODE_STANDBY || pinS2_r) begin
      pwrState_nxt = PWR_STANDBY;
    end else begin
      pwrState_nxt = PWR_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwrState_r <= PWR_ACTIVE;
    end else if (ce) begin
      pwrState_r <= pwrState_nxt;
    end
  end

  // link word: sample with control bits, zero or /K/ fill in standby
  always_comb begin
    ctrlField = '0;
    if (controlBitsPerSample != 2'h0) begin
      ctrlField[`OVR_BIT] = overrangeIn;
    end
    valid_nxt = sampleValid;
    ctrl_nxt = 1'b0;
    case (pwrState_r)
      PWR_ACTIVE: word_nxt = {convSample, ctrlField};
      PWR_STANDBY: begin
        if (fill_r[`FILL_K_BIT]) begin
          word_nxt = `K_WORD;
          ctrl_nxt = 1'b1;
        end else begin
          word_nxt = '0;
        end
      end
      default: begin
        word_nxt = '0;
        valid_nxt = 1'b0;
      end
    endcase
  end

  // fast threshold alert on sample magnitude
  always_comb begin
    magnitude = convSample[SAMPLE_W-1] ? SAMPLE_W'(-convSample) : SAMPLE_W'(convSample);
    alert_nxt = alert_r;
    if (sampleValid) begin
      alert_nxt = magnitude > alertThreshold;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= '0;
      valid_r <= 1'b0;
      ctrl_r <= 1'b0;
      alert_r <= 1'b0;
    end else if (ce) begin
      word_r <= word_nxt;
      valid_r <= valid_nxt;
      ctrl_r <= ctrl_nxt;
      alert_r <= alert_nxt;
    end
  end

  // outputs
  assign linkEnable = pwrState_r != PWR_DOWN;
  assign linkValid = valid_r & linkEnable; // no valid word in power-down
  assign linkWord = word_r;
  assign linkIsControl = ctrl_r;
  assign thresholdAlertPin = alert_r;
  assign fullPowerDown = pwrState_r == PWR_DOWN;
  assign standbyActive = pwrState_r == PWR_STANDBY;
  assign diode1xExport = diode_r == `DIODE_1X;
  assign diode20xExport = diode_r == `DIODE_20X;
  assign referenceExport = refExp_r[`EXPORT_ON_BIT];
  assign commonModeExport = cmExp_r[`EXPORT_ON_BIT];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  pinPowerDown_a: assert property (ce && pinS2_r && !pwrB_r[0] |=> fullPowerDown)
    else $error("pin did not give power-down");
  pinActiveHigh_a: assert property (ce && !pinS2_r && pwrA_r[1:0] == 2'h0 |=>
      pwrState_r == PWR_ACTIVE)
    else $error("low pin still gave a low-power state");
  linkDropped_a: assert property (fullPowerDown |-> !linkEnable && !linkValid)
    else $error("link kept in power-down");
  regPowerDown_a: assert property (ce && pwrA_r[1:0] == 2'h2 |=> fullPowerDown)
    else $error("register power-down ignored");
  standbyZero_a: assert property (ce && standbyActive && pwrState_nxt != PWR_DOWN
      && !fill_r[7] && sampleValid |=> linkValid && linkWord == 16'h0000 && !linkIsControl)
    else $error("standby sample not zero");
  standbyK_a: assert property (ce && standbyActive && fill_r[7] |=>
      linkIsControl && linkWord == 16'hBCBC)
    else $error("standby fill not /K/");
  diodeSelect_a: assert property (ce && bus.wrStb && bus.addr == `OFS_DIODE_SEL
      && bus.wrData == `DIODE_1X |=> diode1xExport && !diode20xExport)
    else $error("1x diode export wrong");
  diodeLarge_a: assert property (ce && bus.wrStb && bus.addr == 15'h18E6
      && bus.wrData == 8'h02 |=> diode20xExport && !diode1xExport)
    else $error("20x diode export wrong");
  ovrAligned_a: assert property (ce && pwrState_r == PWR_ACTIVE && controlBitsPerSample != 0
      |=> linkWord[0] == $past(overrangeIn) && linkWord[15:2] == $past(convSample))
    else $error("overrange not aligned with sample");
  noCtrlBit_a: assert property (ce && pwrState_r == PWR_ACTIVE && controlBitsPerSample == 0
      |=> linkWord[1:0] == 2'h0)
    else $error("control bit sent with none configured");
  stickySet_a: assert property (ce && sampleValid && overrangeIn && int'(vcIndex) < VC_NUM |=>
      sticky_r[$past(vcIndex)])
    else $error("overrange not recorded");
  clearWorks_a: assert property (ce && clrFall != 0 && setVec == 0 |=>
      (sticky_r & $past(clrFall)) == 8'h00)
    else $error("clear sequence did not clear");
  stickyHold_a: assert property (ce |=>
      (($past(sticky_r) & ~$past(clrFall)) & ~sticky_r) == 8'h00)
    else $error("sticky bit lost without clear");
  setWins_a: assert property (ce && (setVec & clrFall) != 0 |=>
      (sticky_r & $past(setVec)) == $past(setVec))
    else $error("coincident set lost to clear");
  alertPin_a: assert property (ce && sampleValid |=>
      thresholdAlertPin == ($past(magnitude) > $past(alertThreshold)))
    else $error("alert pin disagrees with threshold");
  standbyCover_c: cover property (standbyActive && linkValid);
  powerDownCover_c: cover property (ce && !fullPowerDown ##1 fullPowerDown);
  clearCover_c: cover property (ce && clrFall != 0);
  setClearCover_c: cover property (ce && (setVec & clrFall) != 0);
endmodule

// ### shared/pmor_cfg.svh
/*
  constants of the power, diode export and overrange control block:
  register offsets, field positions, reset values and serial frame counts.
  assumes it is included by bare name wherever a constant is needed.
*/
`ifndef PMOR_CFG_SVH
`define PMOR_CFG_SVH
// serial control port frame
`define ADDR_W 15
`define SER_CNT_W 5
`define SER_RW_BIT 14
`define SER_INSTR_LAST 5'h0F
`define SER_FRAME_LAST 5'h17
// register offsets
`define OFS_DEVICE_SELECT 15'h0008
`define OFS_POWER_A 15'h003F
`define OFS_POWER_B 15'h0040
`define OFS_OVR_CLEAR 15'h0562
`define OFS_OVR_STATUS 15'h0563
`define OFS_STANDBY_FILL 15'h0571
`define OFS_REF_EXPORT 15'h18A6
`define OFS_CM_EXPORT 15'h18E3
`define OFS_DIODE_SEL 15'h18E6
// reset and read values
`define REG_RESET 8'h00
`define READ_ZERO 8'h00
// fields
`define PWRA_MODE 1:0
`define MODE_NORMAL 2'h0
`define MODE_STANDBY 2'h1
`define PWRB_PIN_STBY 0
`define FILL_K_BIT 7
`define EXPORT_ON_BIT 0
`define DIODE_1X 8'h01
`define DIODE_20X 8'h02
`define OVR_BIT 0
// link fill words
`define K_WORD 16'hBCBC
`endif

// ### shared/pmor_pkg.sv
/*
  types shared by the control block and its serial port.
  assumes nothing beyond a SystemVerilog compiler.
*/
package pmor_pkg;
  // low-power state of the device
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_STANDBY, PWR_DOWN} power_state_t;
  // phase of a serial control frame
  typedef enum logic [1:0] {SP_INSTR, SP_DATA, SP_DONE} serial_phase_t;
endpackage

// ### shared/reg_access_if.sv
/*
  register access carrier between the serial port and the register bank.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`include "pmor_cfg.svh"
interface reg_access_if;
  logic wrStb;
  logic [`ADDR_W-1:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  // serial port side drives address and writes
  modport port (output wrStb, output addr, output wrData, input rdData);
  // register bank answers reads
  modport bank (input wrStb, input addr, input wrData, output rdData);
endinterface

// ### hw/serial_reg_port.sv
/*
  serial control port slave: 16-bit instruction (read flag, 15-bit address)
  then 8 data bits, msb first, sampled on rising serial clock.
  assumes the serial clock is far slower than clk; pins are synchronised here.
*/
`timescale 1ns/100ps
`include "pmor_cfg.svh"
module serial_reg_port
  import pmor_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial pins
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // register access
  reg_access_if.port bus
);
  logic sclkS1_r, sclkS2_r, sclkS3_r, selS1_r, selS2_r, sdiS1_r, sdiS2_r;
  serial_phase_t phase_r, phase_nxt;
  logic [`SER_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [`ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] outSh_r, outSh_nxt, wrData_r, wrData_nxt;
  logic isRead_r, isRead_nxt, load_r, load_nxt, sdo_r, sdo_nxt, wrStb_r, wrStb_nxt;
  logic rise, fall;

  // pin synchronisers, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      {sclkS1_r, sclkS2_r, sclkS3_r} <= 3'h0;
      {selS1_r, selS2_r} <= 2'h3;
      {sdiS1_r, sdiS2_r} <= 2'h0;
    end else if (ce) begin
      sclkS1_r <= serialClk;
      sclkS2_r <= sclkS1_r;
      sclkS3_r <= sclkS2_r;
      selS1_r <= selectN;
      selS2_r <= selS1_r;
      sdiS1_r <= serialIn;
      sdiS2_r <= sdiS1_r;
    end
  end

  assign rise = sclkS2_r & ~sclkS3_r;
  assign fall = ~sclkS2_r & sclkS3_r;

  // frame sequencing
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    outSh_nxt = outSh_r;
    wrData_nxt = wrData_r;
    isRead_nxt = isRead_r;
    load_nxt = 1'b0;
    sdo_nxt = sdo_r;
    wrStb_nxt = 1'b0;
    if (selS2_r) begin
      phase_nxt = SP_INSTR;
      cnt_nxt = '0;
    end else begin
      if (load_r) begin
        outSh_nxt = bus.rdData; // read data fetched once address is held
      end
      if (fall && phase_r == SP_DATA && isRead_r) begin
        sdo_nxt = outSh_r[7];
        outSh_nxt = {outSh_r[6:0], 1'b0};
      end
      if (rise && phase_r != SP_DONE) begin
        shift_nxt = {shift_r[14:0], sdiS2_r};
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `SER_INSTR_LAST) begin
          isRead_nxt = shift_r[`SER_RW_BIT];
          addr_nxt = {shift_r[13:0], sdiS2_r};
          load_nxt = shift_r[`SER_RW_BIT];
          phase_nxt = SP_DATA;
        end
        if (cnt_r == `SER_FRAME_LAST) begin
          wrStb_nxt = ~isRead_r;
          wrData_nxt = {shift_r[6:0], sdiS2_r};
          phase_nxt = SP_DONE; // extra bits ignored until deselect
        end
      end
    end
  end

  // frame registers
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= SP_INSTR;
      cnt_r <= '0;
      shift_r <= '0;
      addr_r <= '0;
      outSh_r <= '0;
      wrData_r <= '0;
      isRead_r <= 1'b0;
      load_r <= 1'b0;
      sdo_r <= 1'b0;
      wrStb_r <= 1'b0;
    end else if (ce) begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      outSh_r <= outSh_nxt;
      wrData_r <= wrData_nxt;
      isRead_r <= isRead_nxt;
      load_r <= load_nxt;
      sdo_r <= sdo_nxt;
      wrStb_r <= wrStb_nxt;
    end
  end

  assign bus.wrStb = wrStb_r & ce;
  assign bus.addr = addr_r;
  assign bus.wrData = wrData_r;
  assign serialOut = sdo_r;
  assign serialOutEn = ~selS2_r & (phase_r == SP_DATA) & isRead_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  writeOnlyDeselect_a: assert property (bus.wrStb |-> !selS2_r && !isRead_r)
    else $error("write strobe outside a selected write frame");
  noDriveIdle_a: assert property (selS2_r |-> !serialOutEn)
    else $error("serial output driven while deselected");
  writeCover_c: cover property (bus.wrStb);
endmodule

// ### verification/test_power_mode_overrange_status.sv
/*
  self-checking bench for the power, diode export and overrange block.
  assumes the serial control port framing and the latencies of the hand-over,
  a 50 MHz clock and inputs driven at the falling clock edge.
*/
`timescale 1ns/100ps
`include "pmor_cfg.svh"
module test_power_mode_overrange_status;
  // stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic serialClk = 1'b0;
  logic selectN = 1'b1;
  logic serialIn = 1'b0;
  logic lowPowerRequestPin = 1'b0;
  logic signed [13:0] convSample = 14'h0000;
  logic sampleValid = 1'b0;
  logic overrangeIn = 1'b0;
  logic [2:0] vcIndex = 3'h0;
  logic [1:0] controlBitsPerSample = 2'h0;
  logic [13:0] alertThreshold = 14'h3FFF;
  // observed outputs
  logic serialOut, serialOutEn, linkEnable, linkValid, linkIsControl;
  logic thresholdAlertPin, fullPowerDown, standbyActive;
  logic diode1xExport, diode20xExport, referenceExport, commonModeExport;
  logic [15:0] linkWord;
  logic [7:0] rdq;
  logic oenq;
  int errors = 0;
  int totalChecks = 0;

  power_mode_overrange_status DUT (
    .clk(clk), .rst(rst), .ce(ce),
    .serialClk(serialClk), .selectN(selectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn),
    .lowPowerRequestPin(lowPowerRequestPin),
    .convSample(convSample), .sampleValid(sampleValid), .overrangeIn(overrangeIn),
    .vcIndex(vcIndex), .controlBitsPerSample(controlBitsPerSample),
    .alertThreshold(alertThreshold),
    .linkEnable(linkEnable), .linkValid(linkValid), .linkWord(linkWord),
    .linkIsControl(linkIsControl), .thresholdAlertPin(thresholdAlertPin),
    .fullPowerDown(fullPowerDown), .standbyActive(standbyActive),
    .diode1xExport(diode1xExport), .diode20xExport(diode20xExport),
    .referenceExport(referenceExport), .commonModeExport(commonModeExport)
  );

  // 20 ns clock
  always #10 clk = ~clk;

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one serial frame, half period of 5 clk, read bits taken before each rise
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] frame;
    frame = {rd, a, wd};
    @(negedge clk) selectN = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      serialClk = 1'b0;
      serialIn = frame[i];
      repeat (5) @(negedge clk);
      if (i < 8) rdq[i] = serialOut;
      if (i == 0) oenq = serialOutEn;
      serialClk = 1'b1;
      repeat (5) @(negedge clk);
    end
    serialClk = 1'b0;
    repeat (5) @(negedge clk);
    selectN = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp, input string what);
    xfer(1'b1, a, 8'h00);
    chk({8'h00, rdq}, {8'h00, exp}, what);
    chk(oenq, 1'b1, "read output enabled");
  endtask

  // one valid sample, link word registered by return
  task automatic sample(input logic [13:0] s, input logic ovr, input logic [2:0] vc);
    @(negedge clk);
    convSample = s;
    sampleValid = 1'b1;
    overrangeIn = ovr;
    vcIndex = vc;
    @(negedge clk);
    sampleValid = 1'b0;
    overrangeIn = 1'b0;
  endtask

  task automatic test_reset;
    chk({linkEnable, fullPowerDown, standbyActive, diode1xExport, diode20xExport,
         referenceExport, commonModeExport, linkValid, serialOutEn, linkIsControl,
         thresholdAlertPin}, 16'h0400, "idle outputs");
    chk(linkWord, 16'h0000, "idle word");
    rd_chk(`OFS_OVR_STATUS, 8'h00, "status after reset");
  endtask

  task automatic test_link;
    controlBitsPerSample = 2'h1;
    sample(14'h1234, 1'b1, 3'h0);
    chk(linkWord, {14'h1234, 2'b01}, "sample with overrange bit");
    chk(linkValid, 1'b1, "link valid");
    // clock enable low freezes the link register
    ce = 1'b0;
    sample(14'h0AAA, 1'b0, 3'h0);
    chk(linkWord, {14'h1234, 2'b01}, "frozen while disabled");
    ce = 1'b1;
    controlBitsPerSample = 2'h0;
    sample(14'h2001, 1'b1, 3'h0);
    chk(linkWord, {14'h2001, 2'b00}, "no control bits");
    chk(linkIsControl, 1'b0, "not control");
  endtask

  task automatic test_alert;
    logic [13:0] s [4] = '{14'h0101, 14'h0100, 14'h3EFF, 14'h3F00};
    logic e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    alertThreshold = 14'h0100;
    for (int i = 0; i < 4; i++) begin
      sample(s[i], 1'b0, 3'h0);
      chk(thresholdAlertPin, e[i], "alert pin");
    end
  endtask

  task automatic test_pin;
    lowPowerRequestPin = 1'b1;
    repeat (5) @(negedge clk);
    chk({fullPowerDown, standbyActive}, 2'b10, "pin gives power-down");
    chk(linkEnable, 1'b0, "link dropped");
    sample(14'h1555, 1'b0, 3'h0);
    chk(linkWord, 16'h0000, "no data in power-down");
    chk(linkValid, 1'b0, "no valid in power-down");
    lowPowerRequestPin = 1'b0;
    repeat (5) @(negedge clk);
    chk({linkEnable, fullPowerDown}, 2'b10, "pin low wakes");
    wr(`OFS_POWER_B, 8'h01);
    lowPowerRequestPin = 1'b1;
    repeat (5) @(negedge clk);
    chk({linkEnable, standbyActive}, 2'b11, "pin gives standby");
    controlBitsPerSample = 2'h1;
    sample(14'h1555, 1'b0, 3'h0);
    chk(linkWord, 16'h0000, "zero fill");
    chk(linkValid, 1'b1, "zero fill valid");
    wr(`OFS_STANDBY_FILL, 8'h80);
    sample(14'h1555, 1'b0, 3'h0);
    chk(linkWord, `K_WORD, "control fill");
    chk(linkIsControl, 1'b1, "control flag");
    lowPowerRequestPin = 1'b0;
    wr(`OFS_POWER_B, 8'h00);
    wr(`OFS_STANDBY_FILL, 8'h00);
  endtask

  task automatic test_regs;
    logic [1:0] e [4] = '{2'b00, 2'b01, 2'b10, 2'b10};
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_POWER_A, 8'(m));
      chk({fullPowerDown, standbyActive}, e[m], "register mode");
      chk(linkEnable, !e[m][1], "link per mode");
    end
    rd_chk(`OFS_POWER_A, 8'h03, "mode readback");
    wr(`OFS_POWER_A, 8'h00);
  endtask

  task automatic test_diode;
    wr(`OFS_REF_EXPORT, 8'h01);
    wr(`OFS_CM_EXPORT, 8'h01);
    chk({referenceExport, commonModeExport}, 2'b11, "other exports on");
    wr(`OFS_DEVICE_SELECT, 8'h01);
    wr(`OFS_CM_EXPORT, 8'h00);
    wr(`OFS_REF_EXPORT, 8'h00);
    chk({referenceExport, commonModeExport}, 2'b00, "other exports off");
    wr(`OFS_DIODE_SEL, `DIODE_1X);
    chk({diode1xExport, diode20xExport}, 2'b10, "small diode");
    wr(`OFS_DIODE_SEL, `DIODE_20X);
    chk({diode1xExport, diode20xExport}, 2'b01, "large diode");
    rd_chk(`OFS_DEVICE_SELECT, 8'h01, "select readback");
    rd_chk(15'h0100, 8'h00, "unmapped read");
  endtask

  task automatic test_sticky;
    sample(14'h0000, 1'b1, 3'h3);
    sample(14'h0000, 1'b1, 3'h5);
    rd_chk(`OFS_OVR_STATUS, 8'h29, "sticky set");
    wr(`OFS_OVR_STATUS, 8'h00);
    rd_chk(`OFS_OVR_STATUS, 8'h29, "status is read-only");
    wr(`OFS_OVR_CLEAR, 8'h08);
    wr(`OFS_OVR_CLEAR, 8'h00);
    rd_chk(`OFS_OVR_STATUS, 8'h21, "one bit cleared");
    // overrange held on converter 5 across its clear
    @(negedge clk);
    sampleValid = 1'b1;
    overrangeIn = 1'b1;
    vcIndex = 3'h5;
    wr(`OFS_OVR_CLEAR, 8'h20);
    wr(`OFS_OVR_CLEAR, 8'h00);
    sampleValid = 1'b0;
    overrangeIn = 1'b0;
    rd_chk(`OFS_OVR_STATUS, 8'h21, "set beats clear");
    wr(`OFS_OVR_CLEAR, 8'h21);
    wr(`OFS_OVR_CLEAR, 8'h00);
    rd_chk(`OFS_OVR_STATUS, 8'h00, "all cleared");
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("Checks: %0d, errors: %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("Error at %0t: run timed out", $time);
    complete_run();
  end

  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    test_reset();
    test_link();
    test_alert();
    test_pin();
    test_regs();
    test_diode();
    test_sticky();
    complete_run();
  end
endmodule
